/* diag_consts.svh */
// register offsets, field positions, reset values and timing of the self-test config
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH
// register indexes; byte address is four times the index
`define SUP_DIAG_IDX 10'h044
`define CLK_DIAG_IDX 10'h045
`define LOG_DIAG_IDX 10'h046
`define IRQ_STAT_IDX 10'h050
`define IRQ_MASK_IDX 10'h051
`define CFG_RST 16'h0000
`define IRQ_RST 7'h00
// supply self-test register fields
`define GND_A_BIT 2
`define GND_B_BIT 1
`define DGND_BIT 0
// clock self-test register fields
`define SPARE_MSB 15
`define SPARE_LSB 4
`define CLK_FAST_BIT 3
`define CLK_SLOW_BIT 2
`define OSC_WD_BIT 1
`define MCLK_WD_BIT 0
// logic self-test register fields
`define CRC_MSB 9
`define CRC_LSB 8
`define PORT_A_BIT 2
`define PORT_B_BIT 1
`define MAIN_PORT_BIT 0
// force vector / event positions
`define FRC_DGND 0
`define FRC_GND_B 1
`define FRC_GND_A 2
`define FRC_MCLK_WD 3
`define FRC_OSC_WD 4
`define FRC_FAST 5
`define FRC_SLOW 6
`define FRC_CRC 7
`define EV_FREQ 5
`define EV_CRC 6
// longest time from self-test bit to force output
`define CLK_MHZ 100
`define FORCE_TMAX_NS 10
`define FORCE_TMAX_CYC ((`FORCE_TMAX_NS * `CLK_MHZ) / 1000)
`endif

/* diag_pkg.sv */
// types shared by the self-test configuration block
package diag_pkg;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ANSWER = 2'b10
    } apb_phase_t;

    typedef struct packed {
        logic [2:0] sup;
        logic [11:0] spare;
        logic [3:0] clk;
        logic [1:0] crc;
        logic [2:0] port;
        logic [6:0] stat;
        logic [6:0] mask;
        logic [6:0] flt_prev;
        logic [7:0] force_v;
        logic [1:0] crc_pat;
        apb_phase_t ph;
        logic ready;
        logic slverr;
        logic irq;
        logic [31:0] rdata;
    } cfg_state_t;
endpackage : diag_pkg

/* level_sync3.sv */
// three-stage synchroniser with agreement filter for monitor fault flags
`timescale 1ns/1ps
`default_nettype none
module level_sync3 #(
    parameter int W = 7
) (
    input wire logic ref_clk_i, // clock
    input wire logic srst_i, // sync reset
    input wire logic ce_i, // clock enable
    input wire logic [W-1:0] async_i, // raw flags
    output logic [W-1:0] level_o // filtered flags
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    always_comb
    begin
        d = q;
        d.s1 = async_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // s1 is seen only by s2; a change counts once s2 and s3 agree
        for (int i = 0; i < W; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                d.lvl[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            q <= '0;
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
endmodule : level_sync3
`default_nettype wire

/* readback_invert.sv */
// per-pin readback inversion for one port
`timescale 1ns/1ps
`default_nettype none
module readback_invert #(
    parameter int PINS = 3
) (
    input wire logic ref_clk_i, // clock
    input wire logic srst_i, // sync reset
    input wire logic ce_i, // clock enable
    input wire logic invert_i, // port self-test bit
    input wire logic [PINS-1:0] dir_out_i, // 1 = digital output
    input wire logic [2*PINS-1:0] value_i, // pin data fields
    output logic [2*PINS-1:0] readback_o // value as read back
);
    typedef struct packed {
        logic [2*PINS-1:0] rb;
    } rb_state_t;

    rb_state_t q;
    rb_state_t d;
    logic [2*PINS-1:0] nxt;

    for (genvar i = 0; i < PINS; i++)
    begin : g_pin
        // inputs and analog pins read back true so only driven levels are checked
        assign nxt[2*i+1:2*i] = (invert_i && dir_out_i[i]) ?
            ~value_i[2*i+1:2*i] : value_i[2*i+1:2*i]; // R11 R12 R13
    end

    always_comb
    begin
        d = q;
        d.rb = nxt;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            q <= '0;
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    assign readback_o = q.rb;

    property p_invert;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && invert_i && dir_out_i[0]) |=> (readback_o[1:0] == ~$past(value_i[1:0]));
    endproperty
    a_invert: assert property (p_invert) // R11 R12 R13
        else $error("readback not inverted for output pin");
endmodule : readback_invert
`default_nettype wire

/* monitor_diagnostic_injection_cfg.sv */
// self-test injection configuration for ground, clock, map CRC and port monitors
//
// Operation
// [R1] With ground-A self-test on and its monitor on, ground-A open fault is forced in time.
// [R2] With ground-B self-test on and its monitor on, ground-B open fault is forced in time.
// [R3] With digital-ground self-test on and its monitor on, that open fault is forced in time.
// [R4] Twelve spare bits of the clock self-test register store what is written, no effect.
// [R5] Clock-fast self-test with the frequency monitor on forces the frequency fault in time.
// [R6] Clock-slow self-test with the frequency monitor on forces the frequency fault in time.
// [R7] Software never sets clock-fast and clock-slow self-test together, but one after other.
// [R8] Aux oscillator watchdog self-test with that watchdog on forces its fault in time.
// [R9] Main clock watchdog self-test with that watchdog on forces its fault in time.
// [R10] A two-bit field picks map CRC pattern 1 to 3, or none at 0, and forces the CRC fault.
// [R11] Port-A readback self-test inverts read data of port-A pins set as digital outputs.
// [R12] Port-B readback self-test inverts read data of port-B pins set as digital outputs.
// [R13] Main-port readback self-test inverts read data of main-port pins set as outputs.
// [R14] Unused bits 15:10 and 7:3 of the logic self-test register read as zero.
// [R15] Clock and logic self-test registers reset to zero, all self-tests off.
// [R16] A self-test bit does nothing while its monitor is off, and holds until cleared.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "diag_consts.svh"
module monitor_diagnostic_injection_cfg
    import diag_pkg::*;
#(
    parameter int PORT_A_PINS = 3,
    parameter int PORT_B_PINS = 3,
    parameter int MAIN_PINS = 3
) (
    input wire logic ref_clk_i, // 100 MHz clock
    input wire logic srst_i, // sync reset, high
    input wire logic ce_i, // clock enable
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb write
    input wire logic [11:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    input wire logic [3:0] pstrb_i, // apb byte strobes
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error
    output logic irq_o, // level interrupt
    input wire logic ground_a_open_monitor_on_i, // monitor enable
    input wire logic ground_b_open_monitor_on_i, // monitor enable
    input wire logic digital_ground_open_monitor_on_i, // monitor enable
    input wire logic clock_frequency_monitor_on_i, // monitor enable
    input wire logic aux_osc_watchdog_on_i, // watchdog enable
    input wire logic main_clock_watchdog_on_i, // watchdog enable
    input wire logic ground_a_open_fault_i, // monitor flag
    input wire logic ground_b_open_fault_i, // monitor flag
    input wire logic digital_ground_open_fault_i, // monitor flag
    input wire logic clock_frequency_fault_i, // monitor flag
    input wire logic aux_osc_watchdog_fault_i, // monitor flag
    input wire logic main_clock_watchdog_fault_i, // monitor flag
    input wire logic map_crc_fault_i, // checker flag
    output logic [7:0] fault_force_o, // per-monitor force
    output logic [1:0] map_crc_selftest_pattern_o, // crc pattern
    input wire logic [PORT_A_PINS-1:0] port_a_pin_direction_i, // 1 = output
    input wire logic [2*PORT_A_PINS-1:0] port_a_pin_value_i, // data
    output logic [2*PORT_A_PINS-1:0] port_a_readback_o, // read value
    input wire logic [PORT_B_PINS-1:0] port_b_pin_direction_i, // 1 = output
    input wire logic [2*PORT_B_PINS-1:0] port_b_pin_value_i, // data
    output logic [2*PORT_B_PINS-1:0] port_b_readback_o, // read value
    input wire logic [MAIN_PINS-1:0] main_port_pin_direction_i, // 1 = output
    input wire logic [2*MAIN_PINS-1:0] main_port_pin_value_i, // data
    output logic [2*MAIN_PINS-1:0] main_port_readback_o // read value
);
    localparam int FORCE_CYC = `FORCE_TMAX_CYC;
    localparam cfg_state_t RST = '{
        sup: 3'(`CFG_RST), spare: 12'(`CFG_RST), clk: 4'(`CFG_RST), crc: 2'(`CFG_RST),
        port: 3'(`CFG_RST), stat: `IRQ_RST, mask: `IRQ_RST, flt_prev: 7'h00,
        force_v: 8'h00, crc_pat: 2'h0, ph: PH_IDLE, ready: 1'b0,
        slverr: 1'b0, irq: 1'b0, rdata: 32'h0000_0000};

    cfg_state_t q;
    cfg_state_t d;
    logic [6:0] flt_lvl;
    logic [9:0] idx;
    logic hit;
    logic setup;
    logic commit;
    logic [7:0] force_n;
    logic [6:0] diag_on;

    ////////////////////////////////////////////////////////////////////////////
    // fault flags come from analog monitors on other timing

    level_sync3 #(
        .W(7)
    ) u_flt_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .async_i({map_crc_fault_i, clock_frequency_fault_i,
            aux_osc_watchdog_fault_i, main_clock_watchdog_fault_i,
            ground_a_open_fault_i, ground_b_open_fault_i,
            digital_ground_open_fault_i}),
        .level_o(flt_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // port readback inversion

    readback_invert #(
        .PINS(PORT_A_PINS)
    ) u_rb_a (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .invert_i(q.port[`PORT_A_BIT]), // R11
        .dir_out_i(port_a_pin_direction_i),
        .value_i(port_a_pin_value_i),
        .readback_o(port_a_readback_o)
    );

    readback_invert #(
        .PINS(PORT_B_PINS)
    ) u_rb_b (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .invert_i(q.port[`PORT_B_BIT]), // R12
        .dir_out_i(port_b_pin_direction_i),
        .value_i(port_b_pin_value_i),
        .readback_o(port_b_readback_o)
    );

    readback_invert #(
        .PINS(MAIN_PINS)
    ) u_rb_main (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .invert_i(q.port[`MAIN_PORT_BIT]), // R13
        .dir_out_i(main_port_pin_direction_i),
        .value_i(main_port_pin_value_i),
        .readback_o(main_port_readback_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // force terms: a supply or clock self-test bit counts only while its monitor is on; a nonzero CRC field always forces

    assign force_n[`FRC_DGND] = q.sup[`DGND_BIT] && digital_ground_open_monitor_on_i; // R3 R16
    assign force_n[`FRC_GND_B] = q.sup[`GND_B_BIT] && ground_b_open_monitor_on_i; // R2 R16
    assign force_n[`FRC_GND_A] = q.sup[`GND_A_BIT] && ground_a_open_monitor_on_i; // R1 R16
    assign force_n[`FRC_MCLK_WD] = q.clk[`MCLK_WD_BIT] && main_clock_watchdog_on_i; // R9 R16
    assign force_n[`FRC_OSC_WD] = q.clk[`OSC_WD_BIT] && aux_osc_watchdog_on_i; // R8 R16
    assign force_n[`FRC_FAST] = q.clk[`CLK_FAST_BIT] && clock_frequency_monitor_on_i; // R5 R16
    assign force_n[`FRC_SLOW] = q.clk[`CLK_SLOW_BIT] && clock_frequency_monitor_on_i; // R6 R16
    assign force_n[`FRC_CRC] = (q.crc != 2'h0); // R10

    // a pass event is only taken while the matching self-test is forcing
    assign diag_on = {force_n[`FRC_CRC], force_n[`FRC_FAST] | force_n[`FRC_SLOW],
        force_n[4:0]};

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign idx = paddr_i[11:2];
    assign hit = (idx == `SUP_DIAG_IDX) || (idx == `CLK_DIAG_IDX) ||
        (idx == `LOG_DIAG_IDX) || (idx == `IRQ_STAT_IDX) || (idx == `IRQ_MASK_IDX);
    assign setup = psel_i && !penable_i && (q.ph == PH_IDLE);
    assign commit = psel_i && penable_i && (q.ph == PH_ANSWER);

    function automatic logic [31:0] read_mux(input cfg_state_t s, input logic [9:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            `SUP_DIAG_IDX: r[2:0] = s.sup;
            `CLK_DIAG_IDX: r[15:0] = {s.spare, s.clk}; // R4
            `LOG_DIAG_IDX: r[15:0] = {6'h00, s.crc, 5'h00, s.port}; // R14
            `IRQ_STAT_IDX: r[6:0] = s.stat;
            `IRQ_MASK_IDX: r[6:0] = s.mask;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_mux

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        d.flt_prev = flt_lvl;
        d.force_v = force_n;
        d.crc_pat = q.crc; // R10
        d.irq = |(q.stat & q.mask);
        // set wins over a write-one clear in the same cycle
        d.stat = q.stat | (flt_lvl & ~q.flt_prev & diag_on);
        case (q.ph)
            PH_IDLE:
            begin
                if (setup)
                begin
                    d.ph = PH_ANSWER;
                    d.ready = 1'b1;
                    d.slverr = !hit;
                    d.rdata = pwrite_i ? 32'h0000_0000 : read_mux(q, idx);
                end
            end
            PH_ANSWER:
            begin
                if (commit)
                begin
                    d.ph = PH_IDLE;
                    d.ready = 1'b0;
                    d.slverr = 1'b0;
                    if (pwrite_i && pstrb_i[0])
                    begin
                        case (idx)
                            `SUP_DIAG_IDX: d.sup = pwdata_i[2:0];
                            `CLK_DIAG_IDX:
                            begin
                                d.clk = pwdata_i[3:0];
                                d.spare[3:0] = pwdata_i[7:4]; // R4
                            end
                            `LOG_DIAG_IDX: d.port = pwdata_i[2:0];
                            `IRQ_STAT_IDX:
                                d.stat = (q.stat & ~pwdata_i[6:0]) |
                                    (flt_lvl & ~q.flt_prev & diag_on);
                            `IRQ_MASK_IDX: d.mask = pwdata_i[6:0];
                            default: d.mask = q.mask;
                        endcase
                    end
                    if (pwrite_i && pstrb_i[1])
                    begin
                        case (idx)
                            `CLK_DIAG_IDX: d.spare[11:4] = pwdata_i[15:8]; // R4
                            `LOG_DIAG_IDX: d.crc = pwdata_i[`CRC_MSB:`CRC_LSB]; // R10
                            default: d.crc = q.crc;
                        endcase
                    end
                end
            end
            default:
            begin
                d.ph = PH_IDLE;
                d.ready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            q <= RST; // R15
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    assign prdata_o = q.rdata;
    assign pready_o = q.ready;
    assign pslverr_o = q.slverr;
    assign irq_o = q.irq;
    assign fault_force_o = q.force_v;
    assign map_crc_selftest_pattern_o = q.crc_pat;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_gnd_a;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && q.sup[`GND_A_BIT] && ground_a_open_monitor_on_i)
            |-> ##[1:FORCE_CYC] fault_force_o[`FRC_GND_A];
    endproperty
    a_gnd_a: assert property (p_gnd_a) // R1
        else $error("ground A force missing");

    property p_gnd_b;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && q.sup[`GND_B_BIT] && ground_b_open_monitor_on_i)
            |=> fault_force_o[`FRC_GND_B];
    endproperty
    a_gnd_b: assert property (p_gnd_b) // R2
        else $error("ground B force missing");

    property p_dgnd;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && q.sup[`DGND_BIT] && digital_ground_open_monitor_on_i)
            |=> fault_force_o[`FRC_DGND];
    endproperty
    a_dgnd: assert property (p_dgnd) // R3
        else $error("digital ground force missing");

    property p_spare;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && !(commit && pwrite_i && idx == `CLK_DIAG_IDX)) |=> $stable(q.spare);
    endproperty
    a_spare: assert property (p_spare) // R4
        else $error("spare bits changed without a write");

    property p_freq;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && clock_frequency_monitor_on_i && (q.clk[`CLK_FAST_BIT] || q.clk[`CLK_SLOW_BIT]))
            |=> (fault_force_o[`FRC_FAST] || fault_force_o[`FRC_SLOW]);
    endproperty
    a_freq: assert property (p_freq) // R5 R6
        else $error("frequency force missing");

    property p_wd;
        @(posedge ref_clk_i) disable iff (srst_i)
        ((ce_i && q.clk[`OSC_WD_BIT] && aux_osc_watchdog_on_i) |=> fault_force_o[`FRC_OSC_WD])
        and ((ce_i && q.clk[`MCLK_WD_BIT] && main_clock_watchdog_on_i)
            |=> fault_force_o[`FRC_MCLK_WD]);
    endproperty
    a_wd: assert property (p_wd) // R8 R9
        else $error("watchdog force missing");

    property p_crc;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && q.crc != 2'h0) |=> fault_force_o[`FRC_CRC]
            && (map_crc_selftest_pattern_o == $past(q.crc));
    endproperty
    a_crc: assert property (p_crc) // R10
        else $error("crc pattern not forced");

    property p_reserved;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && setup && !pwrite_i && idx == `LOG_DIAG_IDX)
            |=> (prdata_o[15:10] == 6'h00) && (prdata_o[7:3] == 5'h00);
    endproperty
    a_reserved: assert property (p_reserved) // R14
        else $error("reserved bits not zero");

    property p_reset;
        @(posedge ref_clk_i)
        $past(srst_i) |-> (q.clk == 4'h0) && (q.spare == 12'h000) && (q.crc == 2'h0)
            && (q.port == 3'h0) && (q.sup == 3'h0);
    endproperty
    a_reset: assert property (p_reset) // R15
        else $error("self-test bits not cleared by reset");

    property p_mon_off;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ce_i && !ground_a_open_monitor_on_i && !aux_osc_watchdog_on_i)
            |=> !fault_force_o[`FRC_GND_A] && !fault_force_o[`FRC_OSC_WD];
    endproperty
    a_mon_off: assert property (p_mon_off) // R16
        else $error("force while monitor off");

    c_gnd_pass: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        fault_force_o[`FRC_GND_A] ##[1:8] q.stat[`FRC_GND_A]);
    c_crc_pat3: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        map_crc_selftest_pattern_o == 2'h3);
    c_irq: cover property (@(posedge ref_clk_i) disable iff (srst_i) $rose(irq_o));
endmodule : monitor_diagnostic_injection_cfg
`default_nettype wire

/* monitor_diagnostic_injection_cfg_tb.sv */
// self-checking bench for the monitor self-test injection config
`timescale 1ns/1ps
`default_nettype none
`include "diag_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module monitor_diagnostic_injection_cfg_tb;
    import diag_pkg::*;
    logic ref_clk, srst, ce, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [5:0] mon;
    logic [6:0] flt;
    logic [7:0] force_v;
    logic [1:0] crc_pat;
    logic [2:0] dir_a, dir_b, dir_m;
    logic [5:0] val_a, val_b, val_m, rb_a, rb_b, rb_m;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    localparam logic [9:0] RIDX [0:6] = '{`SUP_DIAG_IDX, `SUP_DIAG_IDX, `SUP_DIAG_IDX,
        `CLK_DIAG_IDX, `CLK_DIAG_IDX, `CLK_DIAG_IDX, `CLK_DIAG_IDX};
    localparam int RBIT [0:6] = '{`DGND_BIT, `GND_B_BIT, `GND_A_BIT, `MCLK_WD_BIT,
        `OSC_WD_BIT, `CLK_FAST_BIT, `CLK_SLOW_BIT};
    monitor_diagnostic_injection_cfg dut (.ref_clk_i(ref_clk), .srst_i(srst), .ce_i(ce),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq), .ground_a_open_monitor_on_i(mon[2]),
        .ground_b_open_monitor_on_i(mon[1]), .digital_ground_open_monitor_on_i(mon[0]),
        .clock_frequency_monitor_on_i(mon[5]), .aux_osc_watchdog_on_i(mon[4]),
        .main_clock_watchdog_on_i(mon[3]), .ground_a_open_fault_i(flt[2]),
        .ground_b_open_fault_i(flt[1]), .digital_ground_open_fault_i(flt[0]),
        .clock_frequency_fault_i(flt[5]), .aux_osc_watchdog_fault_i(flt[4]),
        .main_clock_watchdog_fault_i(flt[3]), .map_crc_fault_i(flt[6]),
        .fault_force_o(force_v), .map_crc_selftest_pattern_o(crc_pat),
        .port_a_pin_direction_i(dir_a), .port_a_pin_value_i(val_a), .port_a_readback_o(rb_a),
        .port_b_pin_direction_i(dir_b), .port_b_pin_value_i(val_b), .port_b_readback_o(rb_b),
        .main_port_pin_direction_i(dir_m), .main_port_pin_value_i(val_m),
        .main_port_readback_o(rb_m));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
        input logic [3:0] st, output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        // pready is judged at the rising edge that completes the access; the loop ends once pready is high, the timeout only if it never is
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1);
        `CHK(n, 1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, idx, d, 4'hF, x, e);
    endtask : wr
    task automatic rd(input logic [9:0] idx, output logic [31:0] x);
        logic e;
        apb(1'b0, idx, 32'h00000000, 4'hF, x, e);
    endtask : rd
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_n
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] x;
        logic e;
        rd(`CLK_DIAG_IDX, r);
        `CHK(r, 32'h00000000)
        rd(`LOG_DIAG_IDX, r);
        `CHK(r, 32'h00000000)
        `CHK(force_v, 8'h00)
        apb(1'b0, 10'h3FF, 32'h00000000, 4'hF, x, e);
        `CHK(e, 1'b1)
        `CHK(x, 32'h00000000)
        $display("test reset done");
    endtask : t_reset
    task automatic t_spare();
        logic [31:0] x;
        logic e;
        @(posedge ref_clk);
        mon <= 6'h3F;
        wr(`CLK_DIAG_IDX, 32'h0000FFF0);
        rd(`CLK_DIAG_IDX, r);
        `CHK(r, 32'h0000FFF0)
        wait_n(2);
        `CHK(force_v, 8'h00)
        apb(1'b1, `CLK_DIAG_IDX, 32'h0000ABC0, 4'h1, x, e);
        rd(`CLK_DIAG_IDX, r);
        `CHK(r, 32'h0000FFC0)
        wr(`CLK_DIAG_IDX, 32'h00000000);
        $display("test spare done");
    endtask : t_spare
    task automatic t_force();
        for (int i = 0; i < 7; i++)
        begin
            @(posedge ref_clk);
            mon <= 6'h00;
            // one frequency self-test at a time
            wr(RIDX[i], 32'h1 << RBIT[i]);
            wait_n(2);
            `CHK(force_v[i], 1'b0)
            @(posedge ref_clk);
            mon <= 6'h01 << ((i > 5) ? 5 : i);
            wait_n(2);
            `CHK(force_v, 8'h01 << i)
            wait_n(6);
            `CHK(force_v, 8'h01 << i)
            wr(RIDX[i], 32'h00000000);
            wait_n(2);
            `CHK(force_v, 8'h00)
        end
        $display("test force done");
    endtask : t_force
    task automatic t_crc();
        for (int p = 0; p < 4; p++)
        begin
            wr(`LOG_DIAG_IDX, p << 8);
            wait_n(2);
            `CHK(crc_pat, 2'(p))
            `CHK(force_v[7], (p != 0))
        end
        wr(`LOG_DIAG_IDX, 32'h00000000);
        $display("test crc done");
    endtask : t_crc
    task automatic t_readback();
        @(posedge ref_clk);
        dir_a <= 3'b101;
        dir_b <= 3'b011;
        dir_m <= 3'b110;
        wait_n(3);
        `CHK(rb_a, val_a)
        wr(`LOG_DIAG_IDX, 32'hFFFFFFFF);
        rd(`LOG_DIAG_IDX, r);
        `CHK(r, 32'h00000307)
        wait_n(2);
        `CHK(rb_a, val_a ^ 6'h33)
        `CHK(rb_b, val_b ^ 6'h0F)
        `CHK(rb_m, val_m ^ 6'h3C)
        // clock enable low must freeze the registered readback
        @(posedge ref_clk);
        ce <= 1'b0;
        val_a <= 6'h00;
        wait_n(3);
        `CHK(rb_a, 6'h14)
        @(posedge ref_clk);
        ce <= 1'b1;
        val_a <= 6'h27;
        wr(`LOG_DIAG_IDX, 32'h00000000);
        $display("test readback done");
    endtask : t_readback
    task automatic t_irq();
        @(posedge ref_clk);
        mon <= 6'h04;
        wr(`SUP_DIAG_IDX, 32'h00000004);
        @(posedge ref_clk);
        flt <= 7'h04;
        wait_n(8);
        rd(`IRQ_STAT_IDX, r);
        `CHK(r, 32'h00000004)
        `CHK(irq, 1'b0)
        wr(`IRQ_MASK_IDX, 32'h00000004);
        wait_n(2);
        `CHK(irq, 1'b1)
        wr(`IRQ_STAT_IDX, 32'h00000004);
        wait_n(2);
        `CHK(irq, 1'b0)
        $display("test irq done");
    endtask : t_irq
    task automatic t_reset_again();
        wr(`CLK_DIAG_IDX, 32'h0000000F);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rd(`CLK_DIAG_IDX, r);
        `CHK(r, 32'h00000000)
        `CHK(force_v, 8'h00)
        $display("test reset again done");
    endtask : t_reset_again
    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            results();
        end
    end
    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        mon = 6'h00;
        flt = 7'h00;
        {dir_a, dir_b, dir_m} = '0;
        val_a = 6'h27;
        val_b = 6'h1A;
        val_m = 6'h31;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_spare();
        t_force();
        t_crc();
        t_readback();
        t_irq();
        t_reset_again();
        results();
    end
endmodule : monitor_diagnostic_injection_cfg_tb
`default_nettype wire
